// ---- rtl/sac_params.svh ----
// timing and layout constants of the converter control block
`ifndef SAC_PARAMS_SVH
`define SAC_PARAMS_SVH

`define SAC_RES_BITS 12
`define SAC_CHAN_BITS 3
`define SAC_MSB_IDX 4'hb
`define SAC_LSB_IDX 4'h0
`define SAC_SLOW_IDX 4'h5
// bit decision lengths in conversion-clock half periods
`define SAC_HALF_NORM 3'h2
`define SAC_HALF_SLOW 3'h4
`define SAC_HALF_LAST 3'h3
`define SAC_MSB_TRIAL 12'h0800
`define SAC_RESULT_RST 12'h0000
`define SAC_CHAN_RST 3'h0

`endif

// ---- rtl/sac_pkg.sv ----
// types shared by the converter control block
package sac_pkg;

    typedef enum logic [2:0] {
        SAC_IDLE  = 3'b001,
        SAC_ARMED = 3'b010,
        SAC_CONV  = 3'b100
    } sac_state_e;

    typedef enum logic [2:0] {
        SAC_ACTIVE = 3'b001,
        SAC_NAP    = 3'b010,
        SAC_SLEEP  = 3'b100
    } sac_pwr_e;

    typedef struct packed {
        logic cs_n;
        logic wr_n;
        logic rd_n;
        logic chan_addr_bit2;
        logic chan_addr_bit1;
        logic chan_addr_bit0;
    } sac_host_s;

endpackage

// ---- rtl/sac_conv_ctrl.sv ----
// conversion control of an eight channel 12-bit successive approximation converter
`timescale 1ns/10ps
`default_nettype none
`include "sac_params.svh"

// Contract
// - write strobe with select low starts conversion
// - busy low for whole conversion
// - result driven only with read and select low
// - read strobe plus low address sets power-down
// - select and write low start, tri-state result
// - three address bits pick one of eight
// - sample at start, inputs disconnected during conversion
// - enter on conv clock rise, 13.5 cycles
// - read rise: 00 active, 01 nap, 1x sleep
// - channel latched on write rise, select low
// - new conversion ends nap or sleep
module sac_conv_ctrl
    import sac_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_rstn,
    input wire logic i_ce,
    input wire sac_host_s i_host,
    input wire logic i_conv_clk,
    input wire logic i_cmp_keep,
    output logic o_busy_n,
    output logic [`SAC_RES_BITS-1:0] o_result,
    output logic o_result_oe,
    output logic [`SAC_CHAN_BITS-1:0] o_chan_sel,
    output logic [`SAC_RES_BITS-1:0] o_dac_code,
    output logic o_ain_connect,
    output logic o_nap,
    output logic o_sleep
);

    // ==========================================================
    // strobe decode
    sac_state_e state_q;
    sac_state_e state_d;
    sac_pwr_e pwr_q;
    sac_pwr_e pwr_d;
    logic wr_n_q;
    logic rd_n_q;
    logic cs_n_q;
    logic clk_q;
    logic [3:0] bit_idx_q;
    logic [3:0] bit_idx_d;
    logic [2:0] half_q;
    logic [2:0] half_d;
    logic [`SAC_RES_BITS-1:0] sar_q;
    logic [`SAC_RES_BITS-1:0] sar_d;
    logic [`SAC_RES_BITS-1:0] result_q;
    logic [`SAC_CHAN_BITS-1:0] chan_q;
    logic busy_n_q;
    logic oe_q;
    logic ain_q;

    wire logic [`SAC_CHAN_BITS-1:0] addr_in = {i_host.chan_addr_bit2, i_host.chan_addr_bit1,
        i_host.chan_addr_bit0};
    wire logic wr_fall = wr_n_q && !i_host.wr_n;
    wire logic wr_rise = !wr_n_q && i_host.wr_n;
    wire logic rd_rise = !rd_n_q && i_host.rd_n;
    wire logic start = wr_fall && !i_host.cs_n && (state_q == SAC_IDLE);
    wire logic wr_cs_low = !i_host.wr_n && !i_host.cs_n;
    wire logic conv_rise = i_conv_clk && !clk_q;
    wire logic conv_edge = i_conv_clk != clk_q;
    wire logic chan_load = wr_rise && !i_host.cs_n;
    wire logic pwr_eval = rd_rise && !cs_n_q;
    wire logic read_en = !i_host.rd_n && !i_host.cs_n && !wr_cs_low;

    // ==========================================================
    // bit decision length
    logic [2:0] slot_len;
    assign slot_len = (bit_idx_q == `SAC_SLOW_IDX) ? `SAC_HALF_SLOW :
                      (bit_idx_q == `SAC_LSB_IDX) ? `SAC_HALF_LAST : `SAC_HALF_NORM;
    wire logic [2:0] half_inc = half_q + 3'h1;
    wire logic slot_end = conv_edge && (half_inc == slot_len);
    wire logic last_bit = bit_idx_q == `SAC_LSB_IDX;
    wire logic conv_done = (state_q == SAC_CONV) && slot_end && last_bit;

    // ==========================================================
    // sequencer
    always_comb
    begin
        state_d = state_q;
        bit_idx_d = bit_idx_q;
        half_d = half_q;
        sar_d = sar_q;
        unique case (state_q)
            SAC_IDLE:
            begin
                if (start)
                begin
                    state_d = SAC_ARMED;
                end
            end
            SAC_ARMED:
            begin
                if (conv_rise)
                begin
                    state_d = SAC_CONV;
                    bit_idx_d = `SAC_MSB_IDX;
                    half_d = 3'h0;
                    sar_d = `SAC_MSB_TRIAL;
                end
            end
            SAC_CONV:
            begin
                if (conv_edge)
                begin
                    half_d = half_inc;
                end
                if (slot_end)
                begin
                    half_d = 3'h0;
                    if (!i_cmp_keep)
                    begin
                        sar_d[bit_idx_q] = 1'b0;
                    end
                    if (last_bit)
                    begin
                        state_d = SAC_IDLE;
                    end
                    else
                    begin
                        bit_idx_d = bit_idx_q - 4'h1;
                        sar_d[bit_idx_q - 4'h1] = 1'b1;
                    end
                end
            end
            default:
            begin
                state_d = SAC_IDLE;
            end
        endcase
    end

    // ==========================================================
    // power mode
    always_comb
    begin
        pwr_d = pwr_q;
        if (start)
        begin
            pwr_d = SAC_ACTIVE;
        end
        else if (pwr_eval)
        begin
            if (i_host.chan_addr_bit1)
            begin
                pwr_d = SAC_SLEEP;
            end
            else if (i_host.chan_addr_bit0)
            begin
                pwr_d = SAC_NAP;
            end
            else
            begin
                pwr_d = SAC_ACTIVE;
            end
        end
    end

    // ==========================================================
    // registers
    always_ff @(posedge i_clk_sys or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            state_q <= SAC_IDLE;
            pwr_q <= SAC_ACTIVE;
            wr_n_q <= 1'b1;
            rd_n_q <= 1'b1;
            cs_n_q <= 1'b1;
            clk_q <= 1'b0;
            bit_idx_q <= `SAC_MSB_IDX;
            half_q <= 3'h0;
            sar_q <= `SAC_RESULT_RST;
        end
        else if (i_ce)
        begin
            state_q <= state_d;
            pwr_q <= pwr_d;
            wr_n_q <= i_host.wr_n;
            rd_n_q <= i_host.rd_n;
            cs_n_q <= i_host.cs_n;
            clk_q <= i_conv_clk;
            bit_idx_q <= bit_idx_d;
            half_q <= half_d;
            sar_q <= sar_d;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            busy_n_q <= 1'b1;
            result_q <= `SAC_RESULT_RST;
            chan_q <= `SAC_CHAN_RST;
            oe_q <= 1'b0;
            ain_q <= 1'b1;
        end
        else if (i_ce)
        begin
            if (start)
            begin
                busy_n_q <= 1'b0;
            end
            else if (conv_done)
            begin
                busy_n_q <= 1'b1;
            end
            if (conv_done)
            begin
                result_q <= sar_d;
            end
            if (chan_load)
            begin
                chan_q <= addr_in;
            end
            oe_q <= read_en;
            ain_q <= (state_d != SAC_CONV);
        end
    end

    assign o_busy_n = busy_n_q;
    assign o_result = result_q;
    assign o_result_oe = oe_q;
    assign o_chan_sel = chan_q;
    assign o_dac_code = sar_q;
    assign o_ain_connect = ain_q;
    assign o_nap = pwr_q[1];
    assign o_sleep = pwr_q[2];

endmodule

`default_nettype wire

// ---- verif/sac_ana_model.sv ----
// conversion clock and comparator stand-in
`timescale 1ns/10ps
`default_nettype none
module sac_ana_model (
    input wire logic i_clk,
    input wire logic [11:0] i_dac,
    input wire logic [11:0] i_vin,
    output logic o_ck,
    output logic o_keep
);
    logic [2:0] n_q = 3'h0;
    always_ff @(posedge i_clk) n_q <= n_q + 3'h1;
    assign o_ck = n_q[2];
    assign o_keep = i_dac <= i_vin;
endmodule
`default_nettype wire

// ---- verif/sac_conv_ctrl_props.sv ----
// port assertions of the converter control
`timescale 1ns/10ps
`default_nettype none
module sac_conv_props
    import sac_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_rstn,
    input wire logic i_ce,
    input wire sac_host_s i_host,
    input wire logic i_conv_clk,
    input wire logic o_busy_n,
    input wire logic [11:0] o_result,
    input wire logic o_result_oe,
    input wire logic [2:0] o_chan_sel,
    input wire logic [11:0] o_dac_code,
    input wire logic o_ain_connect,
    input wire logic o_nap,
    input wire logic o_sleep
);
    logic ck_q;
    logic [3:0] rise_q;
    wire rd_ok = !i_host.rd_n && !i_host.cs_n && i_host.wr_n;
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_rstn || !i_ce);
    // clock rises seen while busy
    always_ff @(posedge i_clk_sys or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            ck_q <= 1'b0;
            rise_q <= 4'h0;
        end
        else
        begin
            ck_q <= i_conv_clk;
            rise_q <= o_busy_n ? 4'h0 : rise_q + {3'h0, i_conv_clk & !ck_q};
        end
    end
    sequence s_start;
        $fell(i_host.wr_n) && !i_host.cs_n && o_busy_n;
    endsequence
    sequence s_rd_rise;
        $rose(i_host.rd_n) && !$past(i_host.cs_n) && i_host.wr_n;
    endsequence
    start_wake_a: assert property (s_start |=> !o_busy_n && !o_nap && !o_sleep)
        else $error("start");
    conv_len_a: assert property ($rose(o_busy_n) |-> rise_q == 4'he && o_ain_connect)
        else $error("length");
    res_hold_a: assert property ($changed(o_result) |-> $rose(o_busy_n))
        else $error("result");
    ain_off_a: assert property ($fell(o_ain_connect) |-> !o_busy_n && o_dac_code == 12'h800)
        else $error("sample");
    rd_oe_a: assert property (rd_ok |=> o_result_oe)
        else $error("oe on");
    oe_off_a: assert property (!rd_ok |=> !o_result_oe)
        else $error("oe off");
    chan_lat_a: assert property ($rose(i_host.wr_n) && !i_host.cs_n |=>
        o_chan_sel == $past(i_host[2:0])) else $error("channel");
    pwr_mode_a: assert property (s_rd_rise |=>
        {o_sleep, o_nap} == {$past(i_host[1]), $past(i_host[1:0]) == 2'b01}) else $error("mode");
endmodule
bind sac_conv_ctrl sac_conv_props u_props (.i_clk_sys, .i_rstn, .i_ce, .i_host, .i_conv_clk,
    .o_busy_n, .o_result, .o_result_oe, .o_chan_sel, .o_dac_code, .o_ain_connect, .o_nap,
    .o_sleep);
`default_nettype wire

// ---- verif/testbench.sv ----
// self-checking bench of the converter control
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin err_total++; \
$display("mismatch %s expected %h seen %h", n, e, g); end end
module testbench
    import sac_pkg::*;
;
    typedef struct {logic [2:0] c; logic [11:0] v; logic [1:0] a; logic [1:0] m;} sac_row_s;
    sac_row_s rows [4] = '{'{3'h7, 12'hfff, 2'h1, 2'h1}, '{3'h0, 12'h000, 2'h2, 2'h2},
        '{3'h2, 12'ha5c, 2'h3, 2'h2}, '{3'h5, 12'h800, 2'h0, 2'h0}};
    logic clk = 1'b0;
    logic rstn = 1'b0;
    sac_host_s host = 6'h3f;
    logic [11:0] vin = 12'h000;
    logic ck, keep, busy_n, oe, nap, slp, ain;
    logic ce = 1'b1;
    logic [11:0] res, dac;
    logic [2:0] chan;
    int err_total = 0;
    int num_checks = 0;
    sac_conv_ctrl DUT (.i_clk_sys(clk), .i_rstn(rstn), .i_ce(ce), .i_host(host), .i_conv_clk(ck),
        .i_cmp_keep(keep), .o_busy_n(busy_n), .o_result(res), .o_result_oe(oe), .o_chan_sel(chan),
        .o_dac_code(dac), .o_ain_connect(ain), .o_nap(nap), .o_sleep(slp));
    sac_ana_model u_ana (.i_clk(clk), .i_dac(dac), .i_vin(vin), .o_ck(ck), .o_keep(keep));
    task stop_test;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task step(input logic [5:0] h);
        @(posedge clk);
        #2 host = h;
    endtask
    task conv(input logic [2:0] c);
        @(negedge ck);
        step({3'b001, c});
        step({3'b011, c});
        step(6'h3f);
        for (int k = 0; k < 200 && busy_n !== 1'b1; k++) @(negedge clk);
        `CHK("busy_n", 1'b1, busy_n)
        `CHK("chan", c, chan)
        `CHK("mode", 2'b00, {slp, nap})
        `CHK("ain", 1'b1, ain)
    endtask
    task rdp(input logic [1:0] a, input logic [11:0] v, input logic [1:0] m);
        step({4'h4, a});
        step({4'h4, a});
        `CHK("oe", 1'b1, oe)
        `CHK("result", v, res)
        step({4'h6, a});
        step(6'h3f);
        `CHK("oe", 1'b0, oe)
        `CHK("mode", m, {slp, nap})
    endtask
    initial
    begin
        forever #10 clk = ~clk;
    end
    initial
    begin
        #100000;
        err_total++;
        stop_test();
    end
    initial
    begin
        repeat (4) @(posedge clk);
        #2 rstn = 1'b1;
        `CHK("busy_n", 1'b1, busy_n)
        foreach (rows[i])
        begin
            vin = rows[i].v;
            conv(rows[i].c);
            rdp(rows[i].a, rows[i].v, rows[i].m);
        end
        // clock enable low: strobes must not be seen
        ce = 1'b0;
        step(6'h00);
        step(6'h3f);
        step(6'h3f);
        `CHK("frozen_busy_n", 1'b1, busy_n)
        `CHK("frozen_oe", 1'b0, oe)
        ce = 1'b1;
        step(6'h2b);
        step(6'h3b);
        step(6'h3f);
        `CHK("chan", 3'h5, chan)
        `CHK("busy_n", 1'b1, busy_n)
        @(negedge ck);
        step(6'h00);
        step(6'h00);
        `CHK("oe", 1'b0, oe)
        `CHK("busy_n", 1'b0, busy_n)
        step(6'h3f);
        rstn = 1'b0;
        step(6'h3f);
        `CHK("reset", 32'hc000_0000, {busy_n, ain, oe, nap, slp, res, chan, dac})
        step(6'h3f);
        rstn = 1'b1;
        vin = 12'h123;
        conv(3'h1);
        rdp(2'h0, 12'h123, 2'h0);
        stop_test();
    end
endmodule
`default_nettype wire
